// file: shared/gtl_regs.svh
// Timing constants and counter width for the instrument bus controller
`ifndef GTL_REGS_SVH
`define GTL_REGS_SVH
`define GTL_CLK_PERIOD_NS   20
`define GTL_SETTLE_NORM_NS  2000
`define GTL_SETTLE_FAST_NS  500
`define GTL_SETTLE_NORM_CYC ((`GTL_SETTLE_NORM_NS + `GTL_CLK_PERIOD_NS - 1) / `GTL_CLK_PERIOD_NS)
`define GTL_SETTLE_FAST_CYC (`GTL_SETTLE_FAST_NS / `GTL_CLK_PERIOD_NS)
`define GTL_IFC_NS          100000
`define GTL_IFC_CYC         ((`GTL_IFC_NS + `GTL_CLK_PERIOD_NS - 1) / `GTL_CLK_PERIOD_NS)
`define GTL_POLL_NS         2000
`define GTL_POLL_CYC        ((`GTL_POLL_NS + `GTL_CLK_PERIOD_NS - 1) / `GTL_CLK_PERIOD_NS)
`define GTL_CNT_W           13
`endif

// file: shared/gtl_pkg.sv
// Types shared by the instrument bus controller
package gtl_pkg;
	typedef enum logic [2:0] {
		GTL_OP_CMD,
		GTL_OP_DATA,
		GTL_OP_READ,
		GTL_OP_IFC,
		GTL_OP_PPOLL
	} gtl_op_t;
	typedef logic [7:0] gtl_byte_t;
endpackage

// file: shared/gtl_hs_if.sv
// Source handshake carrier between controller core and source engine
interface gtl_hs_if;
	import gtl_pkg::*;
	logic      start;
	gtl_byte_t data;
	logic      fast;
	logic      busy;
	logic      done;
	modport ctl (output start, data, fast, input busy, done);
	modport src (input start, data, fast, output busy, done);
endinterface

// file: core/gtl_source.sv
// Source side of the three-wire interlocked handshake
`include "gtl_regs.svh"
module gtl_source (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	// Control
	gtl_hs_if.src           hs,
	// Bus lines, true level
	input  wire logic       nrfd_in,
	input  wire logic       ndac_in,
	output logic            dav_true,
	output logic [7:0]      dio_true
);
	import gtl_pkg::*;
	typedef enum logic [2:0] {GTL_S_IDLE, GTL_S_SETTLE, GTL_S_WRDY, GTL_S_WACC, GTL_S_DONE} gtl_src_t;
	gtl_src_t              st_q, st_d;
	logic [`GTL_CNT_W-1:0] cnt_q, cnt_d;
	logic [7:0]            dio_q, dio_d;
	logic                  dav_q, dav_d;

	always_comb begin
		st_d  = st_q;
		cnt_d = cnt_q;
		dio_d = dio_q;
		dav_d = dav_q;
		unique case (st_q)
			GTL_S_IDLE: begin
				if (hs.start) begin
					dio_d = hs.data;
					cnt_d = hs.fast ? `GTL_CNT_W'(`GTL_SETTLE_FAST_CYC)
						: `GTL_CNT_W'(`GTL_SETTLE_NORM_CYC);
					st_d  = GTL_S_SETTLE;
				end
			end
			GTL_S_SETTLE: begin
				if (cnt_q > `GTL_CNT_W'(1))
					cnt_d = cnt_q - `GTL_CNT_W'(1);
				else
					st_d = GTL_S_WRDY;
			end
			GTL_S_WRDY: begin
				if (!nrfd_in) begin
					dav_d = 1'b1;
					st_d  = GTL_S_WACC;
				end
			end
			GTL_S_WACC: begin
				if (!ndac_in) begin
					dav_d = 1'b0;
					st_d  = GTL_S_DONE;
				end
			end
			GTL_S_DONE: st_d = GTL_S_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q  <= GTL_S_IDLE;
			cnt_q <= '0;
			dio_q <= 8'h00;
			dav_q <= 1'b0;
		end else if (clk_en) begin
			st_q  <= st_d;
			cnt_q <= cnt_d;
			dio_q <= dio_d;
			dav_q <= dav_d;
		end
	end

	assign hs.busy  = (st_q != GTL_S_IDLE);
	assign hs.done  = (st_q == GTL_S_DONE);
	assign dav_true = dav_q;
	// Byte stands from the start of settling until the cycle after DAV drops
	assign dio_true = (st_q != GTL_S_IDLE) ? dio_q : 8'h00;
endmodule // gtl_source

// file: core/gtl_ctrl.sv
// Host controller for the instrument bus: controller, talker and listener
`include "gtl_regs.svh"
module gtl_ctrl (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       reset_n,
	input  wire logic       clk_en,
	// Configuration
	input  wire logic       sys_ctrl,
	input  wire logic       fast_timing,
	input  wire logic       remote_en,
	// Request port
	input  wire logic       req_valid,
	input  gtl_pkg::gtl_op_t req_op,
	input  gtl_pkg::gtl_byte_t req_data,
	input  wire logic       req_end,
	output logic            req_ready,
	// Answer port
	output logic            rsp_valid,
	output gtl_pkg::gtl_byte_t rsp_data,
	output logic            rsp_end,
	// Status
	output logic            cic,
	output logic            srq_seen,
	// Bus pins, low true, open drain: oe low drives low
	input  wire logic [7:0] dio_i,
	output logic [7:0]      dio_o,
	output logic [7:0]      dio_oe,
	input  wire logic       dav_i,
	output logic            dav_o,
	output logic            dav_oe,
	input  wire logic       nrfd_i,
	output logic            nrfd_o,
	output logic            nrfd_oe,
	input  wire logic       ndac_i,
	output logic            ndac_o,
	output logic            ndac_oe,
	input  wire logic       atn_i,
	output logic            atn_o,
	output logic            atn_oe,
	input  wire logic       ifc_i,
	output logic            ifc_o,
	output logic            ifc_oe,
	output logic            ren_o,
	output logic            ren_oe,
	input  wire logic       srq_i,
	input  wire logic       eoi_i,
	output logic            eoi_o,
	output logic            eoi_oe
);
	import gtl_pkg::*;
	typedef enum logic [2:0] {
		GTL_C_IDLE, GTL_C_SEND, GTL_C_IFC, GTL_C_LRDY, GTL_C_LACC, GTL_C_LWAIT, GTL_C_POLL
	} gtl_ctl_t;

	// Reset release through two flops
	logic rs1_q, rst_n;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rs1_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rs1_q <= 1'b1;
			rst_n <= rs1_q;
		end
	end

	// True levels of bus lines (negative logic)
	logic [7:0] dio_t;
	logic       dav_t, nrfd_t, ndac_t, atn_t, ifc_t, srq_t, eoi_t;
	assign dio_t  = ~dio_i;
	assign dav_t  = ~dav_i;
	assign nrfd_t = ~nrfd_i;
	assign ndac_t = ~ndac_i;
	assign atn_t  = ~atn_i;
	assign ifc_t  = ~ifc_i;
	assign srq_t  = ~srq_i;
	assign eoi_t  = ~eoi_i;

	gtl_hs_if hs ();
	logic       src_dav;
	logic [7:0] src_dio;
	gtl_source u_src (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.clk_en   (clk_en),
		.hs       (hs),
		.nrfd_in  (nrfd_t),
		.ndac_in  (ndac_t),
		.dav_true (src_dav),
		.dio_true (src_dio)
	);

	gtl_ctl_t              st_q, st_d;
	logic [`GTL_CNT_W-1:0] cnt_q, cnt_d;
	logic                  cic_q, cic_d;
	logic                  atn_q, atn_d;
	logic                  eoi_q, eoi_d;
	logic                  ifc_q, ifc_d;
	logic                  nrfd_q, nrfd_d;
	logic                  ndac_q, ndac_d;
	logic                  rv_q, rv_d;
	logic [7:0]            rd_q, rd_d;
	logic                  re_q, re_d;
	logic                  ren_q, ren_d;
	logic                  srq_q, srq_d;
	logic                  start;

	assign req_ready = (st_q == GTL_C_IDLE) && !hs.busy;
	assign start     = req_valid && req_ready && clk_en;

	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		cic_d  = cic_q;
		atn_d  = atn_q;
		eoi_d  = eoi_q;
		ifc_d  = ifc_q;
		nrfd_d = nrfd_q;
		ndac_d = ndac_q;
		rv_d   = 1'b0;
		rd_d   = rd_q;
		re_d   = re_q;
		ren_d  = sys_ctrl && remote_en;
		srq_d  = cic_q && srq_t;
		hs.start = 1'b0;
		hs.data  = req_data;
		hs.fast  = fast_timing;
		if (cic_q && !sys_ctrl && ifc_t)
			cic_d = 1'b0;
		unique case (st_q)
			GTL_C_IDLE: begin
				if (start) begin
					unique case (req_op)
						GTL_OP_CMD: begin
							if (cic_q) begin
								atn_d    = 1'b1;
								eoi_d    = 1'b0;
								hs.start = 1'b1;
								st_d     = GTL_C_SEND;
							end
						end
						GTL_OP_DATA: begin
							atn_d    = 1'b0;
							eoi_d    = req_end;
							hs.start = 1'b1;
							st_d     = GTL_C_SEND;
						end
						GTL_OP_READ: begin
							atn_d  = 1'b0;
							ndac_d = 1'b1;
							nrfd_d = 1'b0;
							st_d   = GTL_C_LRDY;
						end
						GTL_OP_IFC: begin
							if (sys_ctrl) begin
								ifc_d = 1'b1;
								cnt_d = `GTL_CNT_W'(`GTL_IFC_CYC);
								st_d  = GTL_C_IFC;
							end
						end
						GTL_OP_PPOLL: begin
							if (cic_q) begin
								atn_d = 1'b1;
								eoi_d = 1'b1;
								cnt_d = `GTL_CNT_W'(`GTL_POLL_CYC);
								st_d  = GTL_C_POLL;
							end
						end
						default: ;
					endcase
				end
			end
			GTL_C_SEND: begin
				if (hs.done) begin
					eoi_d = 1'b0;
					st_d  = GTL_C_IDLE;
				end
			end
			GTL_C_IFC: begin
				if (cnt_q > `GTL_CNT_W'(1))
					cnt_d = cnt_q - `GTL_CNT_W'(1);
				else begin
					ifc_d = 1'b0;
					cic_d = 1'b1;
					atn_d = 1'b0;
					st_d  = GTL_C_IDLE;
				end
			end
			GTL_C_LRDY: begin
				if (dav_t) begin
					rd_d   = dio_t;
					re_d   = eoi_t && !atn_t;
					nrfd_d = 1'b1;
					ndac_d = 1'b0;
					rv_d   = 1'b1;
					st_d   = GTL_C_LACC;
				end
			end
			GTL_C_LACC: begin
				if (!dav_t) begin
					ndac_d = 1'b1;
					st_d   = GTL_C_LWAIT;
				end
			end
			GTL_C_LWAIT: begin
				nrfd_d = 1'b0;
				ndac_d = 1'b0;
				st_d   = GTL_C_IDLE;
			end
			GTL_C_POLL: begin
				if (cnt_q > `GTL_CNT_W'(1))
					cnt_d = cnt_q - `GTL_CNT_W'(1);
				else begin
					rd_d  = dio_t;
					re_d  = 1'b0;
					rv_d  = 1'b1;
					eoi_d = 1'b0;
					atn_d = 1'b0;
					st_d  = GTL_C_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q   <= GTL_C_IDLE;
			cnt_q  <= '0;
			cic_q  <= 1'b0;
			atn_q  <= 1'b0;
			eoi_q  <= 1'b0;
			ifc_q  <= 1'b0;
			nrfd_q <= 1'b0;
			ndac_q <= 1'b0;
			rv_q   <= 1'b0;
			rd_q   <= 8'h00;
			re_q   <= 1'b0;
			ren_q  <= 1'b0;
			srq_q  <= 1'b0;
		end else if (clk_en) begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			cic_q  <= cic_d;
			atn_q  <= atn_d;
			eoi_q  <= eoi_d;
			ifc_q  <= ifc_d;
			nrfd_q <= nrfd_d;
			ndac_q <= ndac_d;
			rv_q   <= rv_d;
			rd_q   <= rd_d;
			re_q   <= re_d;
			ren_q  <= ren_d;
			srq_q  <= srq_d;
		end
	end

	// Pin drive: oe low pulls the wired-OR line low (true)
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_dio
			assign dio_o[gi]  = 1'b0;
			assign dio_oe[gi] = ~src_dio[gi];
		end
	endgenerate
	assign dav_o   = 1'b0;
	assign dav_oe  = ~src_dav;
	assign nrfd_o  = 1'b0;
	assign nrfd_oe = ~nrfd_q;
	assign ndac_o  = 1'b0;
	assign ndac_oe = ~ndac_q;
	assign atn_o   = 1'b0;
	assign atn_oe  = ~atn_q;
	assign ifc_o   = 1'b0;
	assign ifc_oe  = ~ifc_q;
	assign ren_o   = 1'b0;
	assign ren_oe  = ~ren_q;
	assign eoi_o   = 1'b0;
	assign eoi_oe  = ~(eoi_q && (src_dav || atn_q));

	assign rsp_valid = rv_q;
	assign rsp_data  = rd_q;
	assign rsp_end   = re_q;
	assign cic       = cic_q;
	assign srq_seen  = srq_q;
endmodule // gtl_ctrl

// file: sim/gtl_ctrl_assertions.sv
// Port checker for the instrument bus controller
module gtl_ctrl_chk (
	// Clock, reset, configuration
	input wire logic	mclk,
	input wire logic	reset_n,
	input wire logic	clk_en,
	input wire logic	sys_ctrl,
	input wire logic	fast_timing,
	// Requests and answers
	input wire logic	req_valid,
	input gtl_pkg::gtl_op_t	req_op,
	input wire logic	req_ready,
	input wire logic	rsp_valid,
	input gtl_pkg::gtl_byte_t	rsp_data,
	input wire logic	cic,
	input wire logic	srq_seen,
	// Bus pins
	input wire logic [7:0]	dio_i,
	input wire logic [7:0]	dio_oe,
	input wire logic	dav_i,
	input wire logic	dav_oe,
	input wire logic	nrfd_i,
	input wire logic	ndac_i,
	input wire logic	ndac_oe,
	input wire logic	atn_oe,
	input wire logic	ifc_oe,
	input wire logic	ren_oe,
	input wire logic	srq_i
);
	timeunit 1ns;
	timeprecision 1ps;
	import gtl_pkg::*;
	localparam int SETTLE_NORM = 99;
	localparam int SETTLE_FAST = 24;
	logic [2:0]	live_q;
	logic [7:0]	dio_prev_q;
	logic [7:0]	quiet_q;
	logic		take;
	assign take = req_valid && req_ready && clk_en;
	// Counts cycles the data drive has stayed unchanged
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			live_q <= 3'h0;
			dio_prev_q <= 8'hff;
			quiet_q <= 8'h00;
		end else begin
			live_q <= {live_q[1:0], 1'b1};
			dio_prev_q <= dio_oe;
			quiet_q <= (dio_oe != dio_prev_q) ? 8'h00 : quiet_q + {7'h00, quiet_q != 8'hff};
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n || !live_q[2]);
	settle_time_a: assert property ($fell(dav_oe) |->
		$stable(dio_oe) && quiet_q >= (fast_timing ? SETTLE_FAST : SETTLE_NORM))
		else $error("data not settled");
	dav_ready_a: assert property ($fell(dav_oe) |-> $past(nrfd_i))
		else $error("valid while not ready");
	dav_release_a: assert property ($rose(dav_oe) |-> $past(ndac_i))
		else $error("valid dropped early");
	dio_hold_a: assert property (!dav_oe && $past(!dav_oe) |-> $stable(dio_oe))
		else $error("data moved while valid");
	cmd_atn_a: assert property (take && cic && req_op == GTL_OP_CMD |=> !atn_oe [*3])
		else $error("attention missing");
	ifc_cic_a: assert property ($rose(ifc_oe) |-> ##[0:2] cic)
		else $error("no control after clear");
	sys_only_a: assert property (!sys_ctrl && $past(!sys_ctrl) |-> ren_oe && ifc_oe)
		else $error("non system drive");
	srq_seen_a: assert property ((cic && !srq_i) [*4] |-> srq_seen)
		else $error("service request missed");
	read_rsp_a: assert property ($fell(dav_i) && dav_oe && !ndac_oe |=>
		rsp_valid && rsp_data == ~$past(dio_i)) else $error("read byte lost");
	cover property (take && req_op == GTL_OP_PPOLL);
	cover property ($fell(dav_oe) && fast_timing);
	cover property (rsp_valid && dav_oe);
endmodule // gtl_ctrl_chk

bind gtl_ctrl gtl_ctrl_chk chk (.*);

// file: sim/gtl_instr.sv
// Instrument model: acceptor, one-byte talker, service request, poll reply
module gtl_instr (
	// Clock and bus levels, low true
	input wire logic	mclk,
	input wire logic [7:0]	dio_i,
	input wire logic	dav_i,
	input wire logic	nrfd_i,
	input wire logic	ndac_i,
	input wire logic	atn_i,
	input wire logic	eoi_i,
	// Scenario controls
	input wire logic	slow,
	input wire logic	talk_go,
	input wire logic	talk_end,
	input wire logic	srq_req,
	input wire logic [7:0]	talk_byte,
	input wire logic [7:0]	pp_resp,
	// Asserted drives and captured byte
	output logic [7:0]	dev_dio,
	output logic		dev_dav,
	output logic		dev_nrfd,
	output logic		dev_ndac,
	output logic		dev_eoi,
	output logic		dev_srq,
	output logic [7:0]	rx_byte,
	output logic		rx_end,
	output logic		rx_atn,
	output logic [7:0]	rx_cnt = 8'h00
);
	timeunit 1ns;
	timeprecision 1ps;
	logic		got_q = 1'b0, hold_q = 1'b1, busy_q = 1'b1;
	logic [3:0]	wait_q = 4'h0;
	logic [1:0]	tk_q = 2'h0;
	assign dev_srq = srq_req;
	assign dev_dav = tk_q == 2'h2;
	assign dev_dio = tk_q[0] ^ tk_q[1] ? talk_byte : (!atn_i && !eoi_i ? pp_resp : 8'h00);
	assign dev_eoi = dev_dav && talk_end;
	assign dev_nrfd = busy_q && !talk_go;
	assign dev_ndac = hold_q && !talk_go;
	always @(posedge mclk) begin
		if (talk_go) begin
			got_q <= 1'b0;
			hold_q <= 1'b1;
		end else if (!dav_i && !got_q) begin
			got_q <= 1'b1;
			busy_q <= 1'b1;
			rx_byte <= ~dio_i;
			rx_end <= !eoi_i;
			rx_atn <= !atn_i;
			rx_cnt <= rx_cnt + 8'h01;
			wait_q <= slow ? 4'hc : 4'h0;
		end else if (wait_q != 4'h0)
			wait_q <= wait_q - 4'h1;
		else if (got_q && dav_i) begin
			got_q <= 1'b0;
			hold_q <= 1'b1;
		end else if (got_q)
			hold_q <= 1'b0;
		else
			busy_q <= 1'b0;
	end
	always @(posedge mclk) begin
		if (!talk_go)
			tk_q <= 2'h0;
		else if (tk_q == 2'h0 && atn_i)
			tk_q <= 2'h1;
		else if (tk_q == 2'h1 && nrfd_i && !ndac_i)
			tk_q <= 2'h2;
		else if (tk_q == 2'h2 && ndac_i)
			tk_q <= 2'h3;
	end
endmodule // gtl_instr

// file: sim/test_gtl_ctrl.sv
// Self-checking bench for the instrument bus controller
module test_gtl_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	import gtl_pkg::*;
	logic		mclk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, sys_ctrl = 1'b0;
	logic		fast_timing = 1'b0, remote_en = 1'b1, req_valid = 1'b0, req_end = 1'b0;
	gtl_op_t	req_op = GTL_OP_CMD;
	gtl_byte_t	req_data = 8'h00;
	logic		slow = 1'b0, talk_go = 1'b0, talk_end = 1'b0, srq_req = 1'b0;
	logic [7:0]	talk_byte = 8'h00, pp_resp = 8'h00, dio_oe, dev_dio, rx_byte, rx_cnt;
	logic		req_ready, rsp_valid, rsp_end, cic, srq_seen, rx_end, rx_atn;
	gtl_byte_t	rsp_data;
	logic		dav_oe, nrfd_oe, ndac_oe, atn_oe, ifc_oe, ren_oe, eoi_oe;
	logic		dev_dav, dev_nrfd, dev_ndac, dev_eoi, dev_srq;
	// Wired lines with pull-ups: any party pulling low wins
	wire logic [7:0]	dio_i = dio_oe & ~dev_dio;
	wire logic	dav_i = dav_oe & ~dev_dav;
	wire logic	nrfd_i = nrfd_oe & ~dev_nrfd;
	wire logic	ndac_i = ndac_oe & ~dev_ndac;
	wire logic	atn_i = atn_oe;
	wire logic	ifc_i = ifc_oe;
	wire logic	eoi_i = eoi_oe & ~dev_eoi;
	wire logic	srq_i = ~dev_srq;
	int		num_errors = 0, comparisons = 0, cycles = 0;
	gtl_ctrl dut (.*, .dio_o(), .dav_o(), .nrfd_o(), .ndac_o(), .atn_o(), .ifc_o(), .ren_o(),
		.eoi_o());
	gtl_instr dev (.*);
	initial forever #10 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			finish_test();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic idle_wait(input int lim);
		int n = 0;
		@(posedge mclk);
		while (req_ready !== 1'b1 && n < lim) begin
			@(posedge mclk);
			n++;
		end
		check({7'h00, req_ready}, 8'h01);
	endtask
	task automatic send(input gtl_op_t op, input gtl_byte_t d, input logic e);
		idle_wait(6000);
		req_valid <= 1'b1;
		req_op <= op;
		req_data <= d;
		req_end <= e;
		@(posedge mclk);
		req_valid <= 1'b0;
	endtask
	task automatic wait_rsp();
		int n = 0;
		@(posedge mclk);
		while (rsp_valid !== 1'b1 && n < 300) begin
			@(posedge mclk);
			n++;
		end
		check({7'h00, rsp_valid}, 8'h01);
	endtask
	task automatic t_refuse();
		send(GTL_OP_CMD, 8'h3f, 1'b0);
		send(GTL_OP_IFC, 8'h00, 1'b0);
		repeat (20) @(posedge mclk);
		check({7'h00, cic}, 8'h00);
		check(rx_cnt, 8'h00);
		check({7'h00, ren_oe}, 8'h01);
	endtask
	task automatic t_ifc();
		@(posedge mclk);
		sys_ctrl <= 1'b1;
		send(GTL_OP_IFC, 8'h00, 1'b0);
		idle_wait(6000);
		repeat (3) @(posedge mclk);
		check({7'h00, cic}, 8'h01);
		check({7'h00, ren_oe}, 8'h00);
		remote_en <= 1'b0;
		repeat (3) @(posedge mclk);
		check({7'h00, ren_oe}, 8'h01);
		remote_en <= 1'b1;
	endtask
	task automatic t_xfer();
		gtl_op_t op[5] = '{GTL_OP_CMD, GTL_OP_CMD, GTL_OP_DATA, GTL_OP_DATA, GTL_OP_CMD};
		logic [7:0] b[5] = '{8'h3f, 8'h21, 8'h41, 8'h0a, 8'h5f};
		for (int i = 0; i < 5; i++) begin
			@(posedge mclk);
			fast_timing <= i[0];
			slow <= i[1];
			send(op[i], b[i], i == 3);
			idle_wait(600);
			check(rx_byte, b[i]);
			check({6'h00, rx_atn, rx_end}, {6'h00, op[i] == GTL_OP_CMD, i == 3});
		end
		check(rx_cnt, 8'h05);
	endtask
	task automatic t_read();
		send(GTL_OP_READ, 8'h00, 1'b0);
		talk_byte <= 8'h5a;
		talk_end <= 1'b1;
		talk_go <= 1'b1;
		wait_rsp();
		check(rsp_data, 8'h5a);
		check({7'h00, rsp_end}, 8'h01);
		talk_go <= 1'b0;
	endtask
	task automatic t_srq();
		srq_req <= 1'b1;
		repeat (8) @(posedge mclk);
		check({7'h00, srq_seen}, 8'h01);
		clk_en <= 1'b0;
		srq_req <= 1'b0;
		repeat (8) @(posedge mclk);
		check({7'h00, srq_seen}, 8'h01);
		clk_en <= 1'b1;
		repeat (8) @(posedge mclk);
		check({7'h00, srq_seen}, 8'h00);
	endtask
	task automatic t_ppoll();
		pp_resp <= 8'h04;
		send(GTL_OP_PPOLL, 8'h00, 1'b0);
		wait_rsp();
		check(rsp_data, 8'h04);
	endtask
	initial begin
		repeat (6) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (3) @(posedge mclk);
		t_refuse();
		t_ifc();
		t_xfer();
		t_read();
		t_srq();
		t_ppoll();
		finish_test();
	end
endmodule // test_gtl_ctrl
